// ### hdl/ucw_control_word.sv
// First control word register bank of the quadrature upconverter
//
// How it works
// - Control word lives at serial address 0x00
// - Bit 31 enables RAM playback
// - Bit 28 routes RAM data, needs bit 31
// - Bits 25:24 select quadrature, tone or DAC
// - Bit 23 enables keying pin, manual only
// - Bit 22 turns inverse sinc filter on
// - Bit 21 starts comb clear, self-clearing
// - Comb clear flushes zeros, then resets accumulators
// - Bit 16 picks sine in tone mode
// - Bit 13 clears phase on each strobe
// - Bit 11 holds phase accumulator in reset
// - Bit 10 reloads ramp timer on strobe
// - Bit 9 keying on, bit 8 auto
// - Bit 7 gates core clocks immediately
// - Bits 6, 4 power down DACs
// - Bit 5 powers down reference input immediately
// - Bit 3 picks sleep pin power-down kind
// - Bit 2 halts baseband when gate low, outside tone mode
// - Bit 1 makes serial data input-only
// - Bit 0 selects least significant first
// - Values take effect on strobe or profile, except bits 7, 5 and 21, which act on the write
module ucw_control_word #(
  parameter int FLUSH_CYCLES = ucw_pkg::COMB_FLUSH_CYCLES
) (
  // Clock, reset and clock enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Serial port controller write side
  input wire logic wr_en_i,
  input wire logic [ucw_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [ucw_pkg::DATA_W-1:0] wr_data_i,
  // Serial port controller read side
  input wire logic [ucw_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [ucw_pkg::DATA_W-1:0] rd_data_o,
  // Transfer strobes
  input wire logic io_update_i,
  input wire logic profile_change_i,
  // Device pins seen by this block
  input wire logic amplitude_keying_pin_i,
  input wire logic transmit_gate_pin_i,
  // RAM playback controls
  output logic ram_play_en_o,
  output logic ram_dest_iq_o,
  // Mode and filter controls
  output logic [1:0] op_mode_o,
  output logic inv_sinc_en_o,
  output logic comb_flush_o,
  output logic comb_acc_reset_o,
  // Synthesizer core controls
  output logic synth_core_sine_sel_o,
  output logic phase_acc_sync_clr_o,
  output logic phase_acc_hold_o,
  // Amplitude keying controls
  output logic amplitude_keying_en_o,
  output logic amplitude_keying_auto_o,
  output logic amplitude_keying_manual_o,
  output logic ramp_rate_reload_o,
  // Power-down controls
  output logic core_clk_off_o,
  output logic dac_pd_o,
  output logic reference_clock_input_pd_o,
  output logic aux_dac_pd_o,
  output logic external_sleep_fast_o,
  output logic baseband_halt_o,
  // Serial port format
  output logic sdio_input_only_o,
  output logic lsb_first_o
);
  import ucw_pkg::*;

  localparam int CNT_W = (FLUSH_CYCLES > 1) ? $clog2(FLUSH_CYCLES) : 1;
  localparam logic [CNT_W-1:0] FLUSH_LAST = CNT_W'(FLUSH_CYCLES - 1);

  // Word as programmed by the host, and what readback shows
  logic [31:0] prog;
  // Word as seen by the device's internal destinations
  logic [31:0] active;
  // Comb clear sequencer
  ucw_clr_state_t clr_state;
  ucw_clr_state_t next_clr_state;
  logic [CNT_W-1:0] clr_cnt;
  logic [CNT_W-1:0] next_clr_cnt;

  // Decoded write, strobe and clear events
  wire ctrl_wr = wr_en_i && (wr_addr_i == CTRL1_ADDR);
  wire xfer = io_update_i || profile_change_i;
  wire clr_done = (clr_state == UCW_ACC_RST);
  wire [31:0] wr_masked = wr_data_i & CTRL1_WR_MASK;

  // Programmed word: write stores, finished clear drops bit 21
  wire [31:0] prog_wr = ctrl_wr ? wr_masked : prog;
  // A fresh request written in the finishing cycle survives
  wire clr_keep = ctrl_wr ? wr_masked[B_COMB_CLR] : (prog[B_COMB_CLR] && !clr_done);
  wire [31:0] next_prog = {prog_wr[31:22], clr_keep, prog_wr[20:0]};

  // Active word: strobe copies all, immediate bits track the write
  wire [31:0] next_active = ((xfer ? next_prog : active) & ~CTRL1_IMM_MASK)
                          | (next_prog & CTRL1_IMM_MASK);

  // Field views of the next active word
  wire [1:0] nx_mode = next_active[B_MODE_HI:B_MODE_LO];
  wire [1:0] nx_key = next_active[B_KEY_EN:B_KEY_AUTO];
  wire nx_tone = (nx_mode == MODE_TONE);
  wire nx_ram = next_active[B_RAM_EN];
  wire nx_ram_iq = nx_ram && next_active[B_RAM_DEST];
  wire nx_sine = nx_tone && next_active[B_SINE_SEL];
  wire nx_key_en = nx_key[1];
  wire nx_key_auto = nx_key[1] && nx_key[0];
  wire nx_pin_live = next_active[B_KEY_PIN_EN] && (nx_key == KEY_MANUAL);
  wire nx_key_manual = nx_pin_live && amplitude_keying_pin_i;
  wire nx_halt = next_active[B_AUTO_PD] && !nx_tone && !transmit_gate_pin_i;
  // Strobe pulses use the word that the strobe makes active
  wire nx_ph_clr = xfer && next_active[B_PH_AUTOCLR];
  wire nx_ramp_reload = xfer && next_active[B_RAMP_RELOAD];

  // Readback shows the programmed word; other addresses read zero
  wire [31:0] next_rd = (rd_addr_i == CTRL1_ADDR) ? prog : 32'h0000_0000;

  // Comb clear sequencer: flush zeros, then pulse accumulator reset
  always_comb begin
    next_clr_state = clr_state;
    next_clr_cnt = clr_cnt;
    unique case (clr_state)
      // Waiting for the host to request a clear
      UCW_IDLE: begin
        if (prog[B_COMB_CLR]) begin
          next_clr_state = UCW_FLUSH;
          next_clr_cnt = '0;
        end
      end
      // Baseband ignored, zeros pushed through the filter
      UCW_FLUSH: begin
        if (clr_cnt == FLUSH_LAST) begin
          next_clr_state = UCW_ACC_RST;
        end else begin
          next_clr_cnt = clr_cnt + CNT_W'(1);
        end
      end
      // One cycle of accumulator reset, then release bit 21
      UCW_ACC_RST: begin
        next_clr_state = UCW_IDLE;
      end
      // Code 2'b11 is unused and falls back to idle
      default: begin
        next_clr_state = UCW_IDLE;
      end
    endcase
  end

  // Register words; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog <= CTRL1_RESET;
      active <= CTRL1_RESET;
      clr_state <= UCW_IDLE;
      clr_cnt <= '0;
    end else if (ce_i) begin
      prog <= next_prog;
      active <= next_active;
      clr_state <= next_clr_state;
      clr_cnt <= next_clr_cnt;
    end
  end

  // Registered readback
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_data_o <= next_rd;
    end
  end

  // Datapath controls from the next active word
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_play_en_o <= 1'b0;
      ram_dest_iq_o <= 1'b0;
      op_mode_o <= MODE_QUAD;
      inv_sinc_en_o <= 1'b0;
      synth_core_sine_sel_o <= 1'b0;
      phase_acc_hold_o <= 1'b0;
    end else if (ce_i) begin
      ram_play_en_o <= nx_ram;
      ram_dest_iq_o <= nx_ram_iq;
      op_mode_o <= nx_mode;
      inv_sinc_en_o <= next_active[B_INV_SINC];
      synth_core_sine_sel_o <= nx_sine;
      phase_acc_hold_o <= next_active[B_PH_HOLD];
    end
  end

  // Comb filter flush level and accumulator reset pulse
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comb_flush_o <= 1'b0;
      comb_acc_reset_o <= 1'b0;
    end else if (ce_i) begin
      comb_flush_o <= (next_clr_state == UCW_FLUSH);
      comb_acc_reset_o <= (next_clr_state == UCW_ACC_RST);
    end
  end

  // Strobe pulses and keying controls
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_acc_sync_clr_o <= 1'b0;
      ramp_rate_reload_o <= 1'b0;
      amplitude_keying_en_o <= 1'b0;
      amplitude_keying_auto_o <= 1'b0;
      amplitude_keying_manual_o <= 1'b0;
    end else if (ce_i) begin
      phase_acc_sync_clr_o <= nx_ph_clr;
      ramp_rate_reload_o <= nx_ramp_reload;
      amplitude_keying_en_o <= nx_key_en;
      amplitude_keying_auto_o <= nx_key_auto;
      amplitude_keying_manual_o <= nx_key_manual;
    end
  end

  // Power-down and serial format controls
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_clk_off_o <= 1'b0;
      dac_pd_o <= 1'b0;
      reference_clock_input_pd_o <= 1'b0;
      aux_dac_pd_o <= 1'b0;
      external_sleep_fast_o <= 1'b0;
      baseband_halt_o <= 1'b0;
      sdio_input_only_o <= 1'b0;
      lsb_first_o <= 1'b0;
    end else if (ce_i) begin
      core_clk_off_o <= next_active[B_CORE_PD];
      dac_pd_o <= next_active[B_DAC_PD];
      reference_clock_input_pd_o <= next_active[B_REF_PD];
      aux_dac_pd_o <= next_active[B_AUX_PD];
      external_sleep_fast_o <= next_active[B_SLEEP_FAST];
      // Gate pin is sampled every cycle so the restart is prompt
      baseband_halt_o <= nx_halt;
      sdio_input_only_o <= next_active[B_SDIO_IN_ONLY];
      lsb_first_o <= next_active[B_LSB_FIRST];
    end
  end

  // Checks on the behaviour above
  sequence s_clr_req;
    ce_i && clr_state == UCW_IDLE && prog[B_COMB_CLR];
  endsequence

  sequence s_flush_run;
    comb_flush_o && !comb_acc_reset_o;
  endsequence

  AST_CLR_SEQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_clr_req |=> s_flush_run)
    else $error("comb flush not asserted after clear request");

  AST_CLR_SELF: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && clr_state == UCW_ACC_RST && !ctrl_wr |=> !prog[B_COMB_CLR])
    else $error("clear bit not released after accumulator reset");

  AST_HOLD_NO_XFER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !xfer |=> inv_sinc_en_o == $past(inv_sinc_en_o))
    else $error("filter enable changed without a strobe");

  AST_XFER_SINC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && xfer |=> inv_sinc_en_o == $past(next_prog[B_INV_SINC]))
    else $error("filter enable not taken on strobe");

  AST_CORE_IMM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && ctrl_wr |=> core_clk_off_o == $past(wr_data_i[B_CORE_PD]))
    else $error("core clock gate not immediate");

  AST_REF_IMM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && ctrl_wr |=> reference_clock_input_pd_o == $past(wr_data_i[B_REF_PD]))
    else $error("reference power-down not immediate");

  AST_OPEN_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (prog & ~CTRL1_WR_MASK) == 32'h0000_0000)
    else $error("open bit stored");

  AST_PH_CLR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && xfer && next_active[B_PH_AUTOCLR] |=> phase_acc_sync_clr_o)
    else $error("phase clear pulse missing");

  AST_SINE_TONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    synth_core_sine_sel_o |-> op_mode_o == MODE_TONE)
    else $error("sine select outside tone mode");

  AST_HALT_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    baseband_halt_o && $past(ce_i) |-> op_mode_o != MODE_TONE && $past(!transmit_gate_pin_i))
    else $error("baseband halted wrongly");

  AST_AUTO_KEY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    amplitude_keying_auto_o |-> amplitude_keying_en_o)
    else $error("auto keying without enable");

  AST_RAM_DEST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ram_dest_iq_o |-> ram_play_en_o)
    else $error("RAM route without playback");

  // A strobe that the clock enable lets through
  sequence s_xfer_taken;
    ce_i && xfer;
  endsequence

  AST_XFER_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> op_mode_o == $past(next_prog[B_MODE_HI:B_MODE_LO]))
    else $error("mode not taken on strobe");

  AST_NO_XFER_MODE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !xfer |=> op_mode_o == $past(op_mode_o))
    else $error("mode changed without a strobe");

  AST_XFER_RAM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> ram_play_en_o == $past(next_prog[B_RAM_EN]))
    else $error("RAM enable not taken on strobe");

  AST_XFER_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> phase_acc_hold_o == $past(next_prog[B_PH_HOLD]))
    else $error("phase hold not taken on strobe");

  AST_XFER_PD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> {dac_pd_o, aux_dac_pd_o} == $past({next_prog[B_DAC_PD], next_prog[B_AUX_PD]}))
    else $error("DAC power-downs not taken on strobe");

  AST_XFER_SLEEP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> external_sleep_fast_o == $past(next_prog[B_SLEEP_FAST]))
    else $error("sleep kind not taken on strobe");

  AST_XFER_FORMAT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_xfer_taken |=> {sdio_input_only_o, lsb_first_o} == $past(next_prog[1:0]))
    else $error("serial format not taken on strobe");

  AST_PH_CLR_ONLY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !xfer |=> !phase_acc_sync_clr_o)
    else $error("phase clear pulse without a strobe");

  AST_RELOAD_ONLY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && !xfer |=> !ramp_rate_reload_o)
    else $error("ramp reload pulse without a strobe");

  AST_MANUAL_KEY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    amplitude_keying_manual_o |-> amplitude_keying_en_o && !amplitude_keying_auto_o)
    else $error("keying pin live outside manual keying");

  AST_ACC_PULSE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ce_i && comb_acc_reset_o |=> !comb_acc_reset_o)
    else $error("accumulator reset longer than one cycle");

  AST_ACC_AFTER_FLUSH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(comb_acc_reset_o) |-> $past(comb_flush_o))
    else $error("accumulator reset without a flush before it");

endmodule

// ### hdl/ucw_pkg.sv
// Constants for the upconverter first control word register bank
package ucw_pkg;

  // Serial address space and the control word's slot in it
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL1_ADDR = 5'h00;
  localparam int DATA_W = 32;

  // Reset value and masks of the control word
  localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL1_WR_MASK = 32'h93E1_2FFF;   // Open bits dropped
  localparam logic [31:0] CTRL1_IMM_MASK = 32'h0000_00A0;  // Bits 7 and 5 act at once

  // Field positions
  localparam int B_RAM_EN = 31;
  localparam int B_RAM_DEST = 28;
  localparam int B_MODE_HI = 25;
  localparam int B_MODE_LO = 24;
  localparam int B_KEY_PIN_EN = 23;
  localparam int B_INV_SINC = 22;
  localparam int B_COMB_CLR = 21;
  localparam int B_SINE_SEL = 16;
  localparam int B_PH_AUTOCLR = 13;
  localparam int B_PH_HOLD = 11;
  localparam int B_RAMP_RELOAD = 10;
  localparam int B_KEY_EN = 9;
  localparam int B_KEY_AUTO = 8;
  localparam int B_CORE_PD = 7;
  localparam int B_DAC_PD = 6;
  localparam int B_REF_PD = 5;
  localparam int B_AUX_PD = 4;
  localparam int B_SLEEP_FAST = 3;
  localparam int B_AUTO_PD = 2;
  localparam int B_SDIO_IN_ONLY = 1;
  localparam int B_LSB_FIRST = 0;

  // Operating mode codes; any code with the upper bit set is the DAC mode
  localparam logic [1:0] MODE_QUAD = 2'h0;
  localparam logic [1:0] MODE_TONE = 2'h1;

  // Keying enable and select pair that means manual keying
  localparam logic [1:0] KEY_MANUAL = 2'h2;

  // Default length of the comb filter flush, in system clocks
  localparam int COMB_FLUSH_CYCLES = 8;

  // States of the comb filter clear sequence
  typedef enum logic [1:0] {
    UCW_IDLE = 2'b00,
    UCW_FLUSH = 2'b01,
    UCW_ACC_RST = 2'b10
  } ucw_clr_state_t;

endpackage

// ### bench/ucw_host_model.sv
// Host model that programs the control word and issues transfer strobes
module ucw_host_model (
  // Clock
  input wire logic core_clk_i,
  // Write side toward the register bank
  output logic wr_en_o,
  output logic [ucw_pkg::ADDR_W-1:0] wr_addr_o,
  output logic [ucw_pkg::DATA_W-1:0] wr_data_o,
  // Transfer strobes
  output logic io_update_o,
  output logic profile_change_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucw_pkg::*;

  // Idle host at time zero
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = '0;
    wr_data_o = '0;
    io_update_o = 1'b0;
    profile_change_o = 1'b0;
  end

  // Whole word per write, held for one rising edge, then released
  task automatic write_word(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(negedge core_clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = addr;
    wr_data_o = data;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    // Released bus shows inverted values, never a stale copy
    wr_addr_o = ~addr;
    wr_data_o = ~data;
  endtask

  // One strobe cycle; returns in the cycle after the taking edge
  task automatic strobe(input logic use_profile);
    @(negedge core_clk_i);
    io_update_o = ~use_profile;
    profile_change_o = use_profile;
    @(negedge core_clk_i);
    io_update_o = 1'b0;
    profile_change_o = 1'b0;
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the first control word register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ucw_pkg::*;

  localparam int FLUSH = 2;  // Short flush keeps the run brief
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic key_pin = 1'b0;
  logic gate_pin = 1'b1;
  logic [ADDR_W-1:0] rd_addr = CTRL1_ADDR;
  logic wr_en, io_upd, prof;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic ram_en, ram_dest, sinc, flush, acc_rst, sine, ph_clr, ph_hold;
  logic k_en, k_auto, k_man, reload, clk_off, dac_pd, ref_pd, aux_pd, fast, halt, sdio, lsb;
  logic [1:0] mode;
  int bad_count = 0;
  int n_tests = 0;

  // Free-running 250 MHz clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  ucw_host_model u_host (.core_clk_i(core_clk), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .io_update_o(io_upd), .profile_change_o(prof));

  ucw_control_word #(.FLUSH_CYCLES(FLUSH)) u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .ce_i(ce), .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .io_update_i(io_upd),
    .profile_change_i(prof), .amplitude_keying_pin_i(key_pin),
    .transmit_gate_pin_i(gate_pin), .ram_play_en_o(ram_en), .ram_dest_iq_o(ram_dest),
    .op_mode_o(mode), .inv_sinc_en_o(sinc), .comb_flush_o(flush),
    .comb_acc_reset_o(acc_rst), .synth_core_sine_sel_o(sine),
    .phase_acc_sync_clr_o(ph_clr), .phase_acc_hold_o(ph_hold),
    .amplitude_keying_en_o(k_en), .amplitude_keying_auto_o(k_auto),
    .amplitude_keying_manual_o(k_man), .ramp_rate_reload_o(reload),
    .core_clk_off_o(clk_off), .dac_pd_o(dac_pd), .reference_clock_input_pd_o(ref_pd),
    .aux_dac_pd_o(aux_pd), .external_sleep_fast_o(fast), .baseband_halt_o(halt),
    .sdio_input_only_o(sdio), .lsb_first_o(lsb));

  // Compare and count; four-state equality so unknowns never match
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Report counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Selected outputs and readback inactive after reset
  task automatic t_reset();
    check("reset outputs", '0, {ram_en, mode, sinc, sine, lsb, clk_off, ph_hold});
    check("reset readback", '0, rd_data);
  endtask

  // All writable bits except the clear bit; immediate bits only before strobe
  task automatic t_all_ones();
    key_pin = 1'b1;
    u_host.write_word(CTRL1_ADDR, 32'hFFDF_FFFF);
    check("immediate bits", 32'h3, {clk_off, ref_pd});
    check("held before strobe", '0, {dac_pd, lsb, mode});
    @(negedge core_clk);
    check("open bits readback", 32'h93C1_2FFF, rd_data);
    u_host.strobe(1'b0);
    check("mode dac", 32'h3, mode);
    check("ram fields", 32'h3, {ram_en, ram_dest});
    check("sinc sine", 32'h2, {sinc, sine});
    check("strobe pulses", 32'h3, {ph_clr, reload});
    check("phase hold", 32'h1, ph_hold);
    check("keying", 32'h6, {k_en, k_auto, k_man});
    check("power downs", 32'h7, {dac_pd, aux_pd, fast});
    check("port format", 32'h3, {sdio, lsb});
    check("halt gate high", 32'h0, halt);
    gate_pin = 1'b0;
    repeat (2) @(negedge core_clk);
    check("pulses end", 32'h0, {ph_clr, reload});
    check("halt gate low", 32'h1, halt);
    gate_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    check("halt gate released", 32'h0, halt);
    gate_pin = 1'b0;
    key_pin = 1'b0;
  endtask

  // Tone mode with manual keying, strobed by a profile change
  task automatic t_tone();
    u_host.write_word(CTRL1_ADDR, 32'h1181_0204);
    check("core clock back on", 32'h0, clk_off);
    u_host.strobe(1'b1);
    check("tone fields", 32'h3, {mode, sine});
    check("dest needs ram", 32'h0, {ram_en, ram_dest});
    check("no halt in tone", 32'h0, halt);
    check("no pulses", 32'h0, {ph_clr, reload, ph_hold});
    key_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    check("manual keying high", 32'h4, {k_man, k_auto, dac_pd});
    key_pin = 1'b0;
    repeat (2) @(negedge core_clk);
    check("manual keying low", 32'h0, k_man);
  endtask

  // Comb clear: flush window, single accumulator reset, bit self-clears
  task automatic t_comb();
    int nf;
    int na;
    nf = 0;
    na = 0;
    u_host.write_word(CTRL1_ADDR, 32'h0220_0000);
    repeat (20) begin
      @(negedge core_clk);
      nf += int'(flush === 1'b1);
      na += int'(acc_rst === 1'b1);
    end
    check("flush cycles", FLUSH, nf);
    check("acc resets", 32'h1, na);
    check("clear bit gone", 32'h0200_0000, rd_data);
    u_host.strobe(1'b0);
    check("mode dac low code", 32'h2, mode);
  endtask

  // Unmapped address and disabled clock enable leave the word alone
  task automatic t_ignored();
    u_host.write_word(5'h01, 32'hFFFF_FFFF);
    ce = 1'b0;
    u_host.write_word(CTRL1_ADDR, 32'hFFFF_FFFF);
    ce = 1'b1;
    @(negedge core_clk);
    check("ignored writes", 32'h0200_0000, rd_data);
    check("ignored immediate", 32'h0, {clk_off, ref_pd});
    rd_addr = 5'h01;
    @(negedge core_clk);
    check("other address reads zero", 32'h0, rd_data);
    rd_addr = CTRL1_ADDR;
  endtask

  // Reset in mid-run brings defaults back, then a write works at once
  task automatic t_mid_reset();
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_reset();
    u_host.write_word(CTRL1_ADDR, 32'h0000_0080);
    check("core off after reset", 32'h1, clk_off);
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_all_ones();
    t_tone();
    t_comb();
    t_ignored();
    t_mid_reset();
    finish_test();
  end
endmodule
